// *** src/mdc_pkg.sv ***
// Shared constants, types and helpers for the data cache coherency block.
// Assumes one clock, synchronous active-low reset, 32-bit physical addresses.
// Functional notes
// (RQ1) Coherency tracked per aligned 32-byte block
// (RQ2) Full 32-bit addresses compared on every lookup; the code compares only address bits 31:5 (index plus tag)
// (RQ3) Lookup indexes directory, compares tag, returns state
// (RQ4) Modified: only copy, newer than memory
// (RQ5) Exclusive: only copy, matches memory
// (RQ6) Shared: other copies exist, never dirty
// (RQ7) Invalid: absent or unusable data
// (RQ8) Gain exclusive ownership before any store
// (RQ9) Broadcast read intent on a miss
// (RQ10) Broadcast modify intent for non-exclusive writes
// (RQ11) Snoop broadcasts, report shared when holding copy
// (RQ12) Retry when modified or snoop conflict
// (RQ13) Separate snoop port; stall only for pushes; the code also stalls ST_LOOK while a qualified snoop targets the same index
// (RQ14) Secondary cache forwards coherent traffic here
// (RQ15) Attribute codes 110 and 111 never programmed
// (RQ16) Guarded locations never loaded speculatively
// (RQ17) Inhibited coherent load hit ignores cache
// (RQ18) Write-through store hitting Modified writes both
// (RQ19) Coherency attribute enables bus-level enforcement
// (RQ20) Load miss reads; fill Exclusive or Shared
// (RQ21) Store: Invalid ownership read, Shared kill
// (RQ22) Snoop qualified by start plus global qualifier
// (RQ23) Each qualified snoop drives retry and shared
// (RQ24) Fixed state code, reset decodes Invalid
// (RQ25) Snoop hit Modified: retry, push, downgrade
`default_nettype none

package mdc_pkg;

  localparam int ADDR_W  = 32;
  localparam int BLK_OFF = 5;   // 32-byte coherency block
  localparam int DATA_W  = 32;

  // Page attribute bit positions: write-through, inhibited, coherent
  localparam int PGA_W = 2;
  localparam int PGA_I = 1;
  localparam int PGA_M = 0;

  // Register map and fields
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_RETRIES = 4'h8;
  localparam int CTRL_CACHE_EN = 0;
  localparam int CTRL_SNOOP_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STS_PUSH = 3;
  localparam int RETRY_CNT_W = 16;

  typedef enum logic [2:0] {
    MESI_I = 3'h0,
    MESI_S = 3'h1,
    MESI_E = 3'h2,
    MESI_M = 3'h4
  } mdc_mesi_t;

  typedef enum logic [2:0] {
    BOP_NONE        = 3'h0,
    BOP_READ        = 3'h1,
    BOP_RFO         = 3'h2,
    BOP_KILL        = 3'h3,
    BOP_WRITE       = 3'h4,
    BOP_READ_SINGLE = 3'h5,
    BOP_PUSH        = 3'h6,
    BOP_SYNC        = 3'h7
  } mdc_bop_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              store;
    logic [2:0]        page_attribute_bits;
    logic              guarded;
    logic              speculative;
  } mdc_cpu_req_t;

  typedef struct packed {
    logic      done;
    logic      cache_hit;
    logic      mem_write;
    logic      refused;
    mdc_mesi_t state;
  } mdc_cpu_rsp_t;

  typedef struct packed {
    logic              valid;
    mdc_bop_t          op;
    logic [ADDR_W-1:0] addr;
    logic              global;
  } mdc_bus_req_t;

  typedef struct packed {
    logic              xfer_begin_n;
    logic              coherent_qualifier_n;
    logic              self;
    mdc_bop_t          op;
    logic [ADDR_W-1:0] addr;
  } mdc_snoop_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    mdc_mesi_t         state;
  } mdc_dir_wr_t;

  // Any code other than S, E or M counts as invalid
  function automatic logic mesi_valid(input mdc_mesi_t s);
    return (s == MESI_S) || (s == MESI_E) || (s == MESI_M);
  endfunction

endpackage

`default_nettype wire

// *** src/mdc_dir.sv ***
// Direct-mapped coherency directory with a processor and a snoop port.
// Assumes the two write ports never target the same index in one cycle.
`default_nettype none

module mdc_dir
  import mdc_pkg::*;
#(
  parameter int SETS = 128
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] cpu_addr_i,
  output var  logic              cpu_hit_o,
  output var  mdc_mesi_t         cpu_state_o,
  output var  mdc_mesi_t         cpu_vstate_o,
  output var  logic [ADDR_W-1:0] cpu_vaddr_o,
  input  wire logic [ADDR_W-1:0] snp_addr_i,
  output var  logic              snp_hit_o,
  output var  mdc_mesi_t         snp_state_o,
  input  wire mdc_dir_wr_t       cwr_i,
  input  wire mdc_dir_wr_t       swr_i
);

  localparam int IW = $clog2(SETS);
  localparam int TW = ADDR_W - BLK_OFF - IW;

  if (SETS < 2 || (SETS & (SETS - 1)) != 0 || IW > ADDR_W - BLK_OFF - 1)
  begin : g_chk
    $error("mdc_dir: SETS must be a power of two that fits the address");
  end

  logic [TW-1:0] tag_q [SETS];
  logic [TW-1:0] tag_d [SETS];
  mdc_mesi_t     st_q  [SETS];
  mdc_mesi_t     st_d  [SETS];
  logic [IW-1:0] ci;
  logic [IW-1:0] si;

  // Index and full-tag compare on both ports
  always_comb
  begin
    ci = cpu_addr_i[BLK_OFF +: IW];
    si = snp_addr_i[BLK_OFF +: IW];
    cpu_hit_o    = mesi_valid(st_q[ci]) &&
                   tag_q[ci] == cpu_addr_i[ADDR_W-1 -: TW]; // RQ2 RQ3
    cpu_state_o  = cpu_hit_o ? st_q[ci] : MESI_I; // RQ3 RQ7
    cpu_vstate_o = st_q[ci];
    cpu_vaddr_o  = {tag_q[ci], ci, {BLK_OFF{1'b0}}}; // RQ1
    snp_hit_o    = mesi_valid(st_q[si]) &&
                   tag_q[si] == snp_addr_i[ADDR_W-1 -: TW]; // RQ13
    snp_state_o  = snp_hit_o ? st_q[si] : MESI_I;
  end

  // Next directory contents; reset clears every block to invalid
  always_comb
  begin
    tag_d = tag_q;
    st_d  = st_q;
    if (!rst_n_i)
    begin
      for (int i = 0; i < SETS; i++)
        st_d[i] = MESI_I; // RQ24
    end
    else
    begin
      if (cwr_i.en)
      begin
        tag_d[cwr_i.addr[BLK_OFF +: IW]] = cwr_i.addr[ADDR_W-1 -: TW];
        st_d[cwr_i.addr[BLK_OFF +: IW]]  = cwr_i.state;
      end
      if (swr_i.en)
        st_d[swr_i.addr[BLK_OFF +: IW]] = swr_i.state;
    end
  end

  // Register directory
  always_ff @(posedge clk_i)
  begin
    tag_q <= tag_d;
    st_q  <= st_d;
  end

endmodule // mdc_dir

`default_nettype wire

// *** src/mdc_coherency.sv ***
// Data cache coherency controller: processor requests, bus master, snoop.
// Assumes bus and snoop signals come from logic on the same clock.
`default_nettype none

module mdc_coherency
  import mdc_pkg::*;
#(
  parameter int SETS = 128
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              cpu_req_valid_i,
  input  wire mdc_cpu_req_t      cpu_req_i,
  output var  logic              cpu_ready_o,
  output var  mdc_cpu_rsp_t      cpu_rsp_o,
  output var  mdc_bus_req_t      bus_req_o,
  input  wire logic              bus_done_i,
  input  wire logic              bus_retry_n_i,
  input  wire logic              bus_shared_n_i,
  input  wire mdc_snoop_t        snoop_i,
  output var  logic              snoop_retry_n_o,
  output var  logic              snoop_shared_n_o,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output var  logic [DATA_W-1:0] reg_rdata_o
);

  localparam int IW = $clog2(SETS);

  if (SETS < 2 || IW > ADDR_W - BLK_OFF - 1)
  begin : g_chk
    $error("mdc_coherency: SETS out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOK,
    ST_CAST,
    ST_BUS,
    ST_PUSH
  } mdc_fsm_t;

  // Same directory index, used for conflict checks
  function automatic logic same_idx(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] b);
    return a[BLK_OFF +: IW] == b[BLK_OFF +: IW];
  endfunction

  // Same 32-byte block
  function automatic logic same_blk(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:BLK_OFF] == b[ADDR_W-1:BLK_OFF]; // RQ1
  endfunction

  mdc_fsm_t          state_q, state_d, ret_q, ret_d;
  mdc_cpu_req_t      req_q, req_d;
  mdc_cpu_rsp_t      rsp_q, rsp_d;
  mdc_bus_req_t      bus_q, bus_d;
  logic              ready_q, ready_d;
  logic              push_q, push_d;
  logic [ADDR_W-1:0] paddr_q, paddr_d;
  mdc_mesi_t         pnext_q, pnext_d;
  logic              sretry_q, sretry_d;
  logic              sshared_q, sshared_d;
  logic [1:0]        ctrl_q, ctrl_d;
  logic [RETRY_CNT_W-1:0] rcnt_q, rcnt_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  logic              cpu_hit;
  mdc_mesi_t         cpu_st, cpu_vst, snp_st;
  logic [ADDR_W-1:0] cpu_vaddr;
  logic              snp_hit;
  mdc_dir_wr_t       cwr, swr;
  logic              snp_qual, snp_data, busy_conf, push_set;
  logic              ci, wt, coh, cache_en, snoop_en;

  assign cache_en = ctrl_q[CTRL_CACHE_EN];
  assign snoop_en = ctrl_q[CTRL_SNOOP_EN];

  mdc_dir #(
    .SETS (SETS)
  ) u_dir (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .cpu_addr_i   (req_q.addr),
    .cpu_hit_o    (cpu_hit),
    .cpu_state_o  (cpu_st),
    .cpu_vstate_o (cpu_vst),
    .cpu_vaddr_o  (cpu_vaddr),
    .snp_addr_i   (snoop_i.addr),
    .snp_hit_o    (snp_hit),
    .snp_state_o  (snp_st),
    .cwr_i        (cwr),
    .swr_i        (swr)
  );

  // Snoop qualification and response on the second directory port
  always_comb
  begin
    snp_qual = !snoop_i.xfer_begin_n && snoop_en &&
               (!snoop_i.coherent_qualifier_n ||
                (snoop_i.self && snoop_i.op == BOP_SYNC)); // RQ22
    snp_data  = snp_qual && !snoop_i.self && snoop_i.op != BOP_SYNC;
    busy_conf = state_q != ST_IDLE && same_idx(req_q.addr, snoop_i.addr);
    sretry_d  = 1'b1;
    sshared_d = 1'b1;
    swr       = '0;
    push_set  = 1'b0;
    paddr_d   = paddr_q;
    pnext_d   = pnext_q;
    if (snp_data) // RQ23
    begin
      if ((push_q && same_blk(paddr_q, snoop_i.addr)) || busy_conf)
        sretry_d = 1'b0; // RQ12
      else if (snp_hit && snp_st == MESI_M)
      begin
        sretry_d = 1'b0; // RQ12 RQ25
        if (!push_q)
        begin
          push_set = 1'b1; // RQ25
          paddr_d  = {snoop_i.addr[ADDR_W-1:BLK_OFF], {BLK_OFF{1'b0}}};
          pnext_d  = snoop_i.op == BOP_READ ? MESI_S : MESI_I; // RQ25
        end
      end
      else if (snp_hit)
      begin
        sshared_d = 1'b0; // RQ11
        swr.en    = 1'b1;
        swr.addr  = snoop_i.addr;
        swr.state = snoop_i.op == BOP_READ ? MESI_S : MESI_I; // RQ6 RQ8
      end
    end
  end

  // Processor request sequencing and bus mastering
  always_comb
  begin
    state_d = state_q;
    ret_d   = ret_q;
    req_d   = req_q;
    rsp_d   = '0;
    bus_d   = bus_q;
    cwr     = '0;
    push_d  = push_q || push_set;
    ci  = req_q.page_attribute_bits[PGA_I] || !cache_en; // RQ19
    wt  = req_q.page_attribute_bits[PGA_W];
    coh = req_q.page_attribute_bits[PGA_M]; // RQ19
    if (bus_done_i)
      bus_d.valid = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (push_q)
        begin
          state_d = ST_PUSH; // RQ13
          ret_d   = ST_IDLE;
          bus_d   = '{1'b1, BOP_PUSH, paddr_q, 1'b1};
        end
        else if (cpu_req_valid_i && ready_q)
        begin
          req_d   = cpu_req_i;
          state_d = ST_LOOK;
        end
      end
      ST_LOOK:
      begin
        rsp_d.state = cpu_st;
        if (push_q)
        begin
          state_d = ST_PUSH; // RQ13
          ret_d   = ST_LOOK;
          bus_d   = '{1'b1, BOP_PUSH, paddr_q, 1'b1};
        end
        else if (snp_qual && same_idx(req_q.addr, snoop_i.addr))
          state_d = ST_LOOK; // Let the snoop settle the block first
        else if (req_q.guarded && req_q.speculative)
        begin
          rsp_d.done    = 1'b1; // RQ16
          rsp_d.refused = 1'b1;
          state_d       = ST_IDLE;
        end
        else if (ci)
        begin
          // Inhibited access bypasses any cached copy unchanged
          state_d = ST_BUS; // RQ17
          bus_d   = '{1'b1, req_q.store ? BOP_WRITE : BOP_READ_SINGLE,
                      req_q.addr, coh};
        end
        else if (req_q.store && wt)
        begin
          state_d = ST_BUS; // RQ18
          bus_d   = '{1'b1, BOP_WRITE, req_q.addr, coh};
        end
        else if (cpu_hit && (!req_q.store || cpu_st == MESI_M))
        begin
          rsp_d.done      = 1'b1; // RQ4 RQ5 RQ6
          rsp_d.cache_hit = 1'b1;
          state_d         = ST_IDLE;
        end
        else if (cpu_hit && cpu_st == MESI_E)
        begin
          cwr             = '{1'b1, req_q.addr, MESI_M}; // RQ21 RQ8
          rsp_d.done      = 1'b1;
          rsp_d.cache_hit = 1'b1;
          rsp_d.state     = MESI_M;
          state_d         = ST_IDLE;
        end
        else if (cpu_hit)
        begin
          state_d = ST_BUS; // RQ10 RQ21
          bus_d   = '{1'b1, BOP_KILL, req_q.addr, coh};
        end
        else
        begin
          // Miss: read or ownership read, after copy-back of a Modified victim
          bus_d = '{1'b1, req_q.store ? BOP_RFO : BOP_READ,
                    req_q.addr, coh}; // RQ9 RQ10 RQ20 RQ21
          state_d = ST_BUS;
          if (cpu_vst == MESI_M)
          begin
            state_d = ST_CAST;
            bus_d   = '{1'b1, BOP_PUSH, cpu_vaddr, 1'b1};
          end
        end
      end
      ST_CAST:
      begin
        if (bus_done_i && !bus_retry_n_i)
          state_d = ST_LOOK;
        else if (bus_done_i)
        begin
          cwr     = '{1'b1, cpu_vaddr, MESI_I};
          state_d = ST_LOOK;
        end
      end
      ST_BUS:
      begin
        if (bus_done_i && !bus_retry_n_i)
          state_d = ST_LOOK; // RQ20 RQ21
        else if (bus_done_i)
        begin
          rsp_d.done      = 1'b1;
          rsp_d.state     = cpu_st;
          rsp_d.mem_write = bus_q.op == BOP_WRITE;
          rsp_d.cache_hit = bus_q.op == BOP_WRITE && cpu_hit && !ci;
          state_d         = ST_IDLE;
          unique case (bus_q.op)
            BOP_READ:
            begin
              cwr.en    = 1'b1;
              cwr.addr  = req_q.addr;
              cwr.state = (!bus_shared_n_i && coh) ? MESI_S
                                                   : MESI_E; // RQ20
            end
            BOP_RFO, BOP_KILL:
              cwr = '{1'b1, req_q.addr, MESI_M}; // RQ8 RQ21
            default:
              cwr = '0; // RQ17 RQ18
          endcase
          if (cwr.en)
            rsp_d.state = cwr.state;
        end
      end
      ST_PUSH:
      begin
        if (bus_done_i && !bus_retry_n_i)
          bus_d = '{1'b1, BOP_PUSH, paddr_q, 1'b1};
        else if (bus_done_i)
        begin
          cwr     = '{1'b1, paddr_q, pnext_q}; // RQ25
          push_d  = 1'b0;
          state_d = ret_q;
          if (ret_q == ST_IDLE && push_set)
            state_d = ST_IDLE;
        end
      end
    endcase
    ready_d = state_d == ST_IDLE && !push_d; // RQ13
    if (!rst_n_i)
    begin
      state_d = ST_IDLE;
      ret_d   = ST_IDLE;
      req_d   = '0;
      rsp_d   = '0;
      bus_d   = '0;
      push_d  = 1'b0;
      ready_d = 1'b0;
    end
  end

  // Register port: control, status, retry counter
  always_comb
  begin
    ctrl_d  = ctrl_q;
    rcnt_d  = rcnt_q;
    rdata_d = '0;
    if (!sretry_d)
      rcnt_d = rcnt_q + RETRY_CNT_W'(1);
    if (reg_we_i && reg_addr_i == REG_CTRL)
      ctrl_d = reg_wdata_i[1:0];
    if (reg_we_i && reg_addr_i == REG_RETRIES)
      rcnt_d = '0;
    if (reg_re_i)
    begin
      unique case (reg_addr_i)
        REG_CTRL:    rdata_d = {{(DATA_W-2){1'b0}}, ctrl_q};
        REG_STATUS:  rdata_d = {{(DATA_W-STS_PUSH-1){1'b0}}, push_q,
                                3'(state_q)};
        REG_RETRIES: rdata_d = {{(DATA_W-RETRY_CNT_W){1'b0}}, rcnt_q};
        default:     rdata_d = '0;
      endcase
    end
    if (!rst_n_i)
    begin
      ctrl_d  = CTRL_RESET;
      rcnt_d  = '0;
      rdata_d = '0;
    end
  end

  // Register all state
  always_ff @(posedge clk_i)
  begin
    state_q   <= state_d;
    ret_q     <= ret_d;
    req_q     <= req_d;
    rsp_q     <= rsp_d;
    bus_q     <= bus_d;
    ready_q   <= ready_d;
    push_q    <= push_d;
    paddr_q   <= rst_n_i ? paddr_d : '0;
    pnext_q   <= rst_n_i ? pnext_d : MESI_I;
    sretry_q  <= rst_n_i ? sretry_d : 1'b1;
    sshared_q <= rst_n_i ? sshared_d : 1'b1;
    ctrl_q    <= ctrl_d;
    rcnt_q    <= rcnt_d;
    rdata_q   <= rdata_d;
  end

  assign cpu_ready_o      = ready_q;
  assign cpu_rsp_o        = rsp_q;
  assign bus_req_o        = bus_q;
  assign snoop_retry_n_o  = sretry_q;
  assign snoop_shared_n_o = sshared_q;
  assign reg_rdata_o      = rdata_q;

endmodule // mdc_coherency

`default_nettype wire

// *** testbench/mdc_coherency_monitor.sv ***
// Checker for the coherency controller: snoop, processor and bus timing.
// Assumes it is bound onto mdc_coherency; one clock, sync active-low reset.
`default_nettype none

module mdc_coherency_monitor
  import mdc_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic         cpu_req_valid_i,
  input wire mdc_cpu_req_t cpu_req_i,
  input wire logic         cpu_ready_o,
  input wire mdc_cpu_rsp_t cpu_rsp_o,
  input wire mdc_bus_req_t bus_req_o,
  input wire logic         bus_done_i,
  input wire logic         bus_retry_n_i,
  input wire mdc_snoop_t   snoop_i,
  input wire logic         snoop_retry_n_o,
  input wire logic         snoop_shared_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic         take;
  logic         qual;
  logic         done;
  mdc_cpu_req_t req_q;

  // Request taken, answer given, snoop qualified
  assign take = cpu_req_valid_i && cpu_ready_o;
  assign done = cpu_rsp_o.done && !cpu_rsp_o.refused;
  assign qual = !snoop_i.xfer_begin_n && (!snoop_i.coherent_qualifier_n
              || (snoop_i.self && snoop_i.op == BOP_SYNC));

  // Request under way, kept for the answer checks
  always_ff @(posedge clk_i)
  begin
    if (take)
      req_q <= cpu_req_i;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SNP_QUAL: assert property (
    !(snoop_retry_n_o && snoop_shared_n_o) |-> $past(qual))
    else $error("snoop answer without qualified snoop");
  AST_SNP_ONE: assert property (
    !snoop_retry_n_o |=> snoop_retry_n_o || $past(qual))
    else $error("retry answer longer than one cycle");
  AST_TAKE: assert property (
    take |=> !cpu_ready_o ##[1:300] cpu_rsp_o.done)
    else $error("request taken but not answered");
  AST_REFUSE: assert property (
    take && cpu_req_i.guarded && cpu_req_i.speculative |=>
    !bus_req_o.valid ##1 (cpu_rsp_o.done && cpu_rsp_o.refused
    && !bus_req_o.valid))
    else $error("guarded speculative load not refused");
  AST_BUS_HOLD: assert property (
    bus_req_o.valid && !bus_done_i |=> bus_req_o.valid
    && $stable(bus_req_o.op) && $stable(bus_req_o.addr))
    else $error("bus request changed before done");
  AST_BUS_DROP: assert property (
    bus_req_o.valid && bus_done_i && bus_retry_n_i |=> !bus_req_o.valid)
    else $error("bus request kept after done");
  AST_GLOBAL: assert property (
    $rose(bus_req_o.valid) |-> bus_req_o.global ==
    (bus_req_o.op == BOP_PUSH || req_q.page_attribute_bits[PGA_M]))
    else $error("global flag not the coherency attribute");
  AST_STORE_M: assert property (
    done && req_q.store && req_q.page_attribute_bits == 3'h1
    |-> cpu_rsp_o.state == MESI_M)
    else $error("cacheable store did not end modified");
  AST_LOAD_FILL: assert property (
    done && !req_q.store && req_q.page_attribute_bits == 3'h1
    |-> cpu_rsp_o.state != MESI_I)
    else $error("cacheable load left block invalid");
  AST_INHIB: assert property (
    done && !req_q.store && req_q.page_attribute_bits[PGA_I]
    |-> !cpu_rsp_o.cache_hit)
    else $error("inhibited load used cache data");
  AST_WT: assert property (
    done && req_q.store && req_q.page_attribute_bits[PGA_W]
    |-> cpu_rsp_o.mem_write)
    else $error("write-through store missed memory");

  // Main scenarios reached
  COV_REFUSE: cover property (take && cpu_req_i.guarded
                              && cpu_req_i.speculative);
  COV_RETRY: cover property (!snoop_retry_n_o);
  COV_RFO: cover property ($rose(bus_req_o.valid)
                           && bus_req_o.op == BOP_RFO);

endmodule // mdc_coherency_monitor

bind mdc_coherency mdc_coherency_monitor u_mon (
  .clk_i, .rst_n_i, .cpu_req_valid_i, .cpu_req_i, .cpu_ready_o,
  .cpu_rsp_o, .bus_req_o, .bus_done_i, .bus_retry_n_i, .snoop_i,
  .snoop_retry_n_o, .snoop_shared_n_o);

`default_nettype wire

// *** testbench/mdc_bus_model.sv ***
// Far side of the bus: answers each bus request after a set latency.
// Assumes valid is held until done and drops the cycle after it.
`default_nettype none

module mdc_bus_model
  import mdc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire mdc_bus_req_t bus_req_i,
  input  wire logic [2:0]   lat_i,
  input  wire logic         shared_i,
  input  wire logic         retry_i,
  output var  logic         done_o,
  output var  logic         retry_n_o,
  output var  logic         shared_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;
  logic       retried_q;
  logic       fire;

  // Completion once the latency has run out
  assign fire = bus_req_i.valid && !done_o && cnt_q >= lat_i;

  // Answers of the other masters; lines pulled high between answers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      done_o <= 1'b0;
      cnt_q <= 3'h0;
      retried_q <= 1'b0;
      retry_n_o <= 1'b1;
      shared_n_o <= 1'b1;
    end
    else
    begin
      done_o <= fire;
      cnt_q <= (bus_req_i.valid && !fire && !done_o) ? cnt_q + 3'h1 : 3'h0;
      retry_n_o <= !(fire && retry_i && !retried_q);
      shared_n_o <= !(fire && shared_i);
      retried_q <= retry_i && (retried_q || fire);
    end
  end

endmodule // mdc_bus_model

`default_nettype wire

// *** testbench/mdc_coherency_test.sv ***
// Self-checking bench for the coherency controller with a bus model.
// Assumes the package, design and checker are compiled before this file.
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      $display("[FAIL] %s exp %h got %h", nm, ex, got); \
      num_errors++; \
    end \
  end

module mdc_coherency_test
  import mdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clk_i, rst_n_i, cpu_req_valid_i, cpu_ready_o;
  mdc_cpu_req_t cpu_req_i;
  mdc_cpu_rsp_t cpu_rsp_o;
  mdc_bus_req_t bus_req_o;
  logic         bus_done_i, bus_retry_n_i, bus_shared_n_i;
  mdc_snoop_t   snoop_i;
  logic         snoop_retry_n_o, snoop_shared_n_o;
  logic [3:0]   reg_addr_i;
  logic [31:0]  reg_wdata_i, reg_rdata_o;
  logic         reg_we_i, reg_re_i, shared, retry, re_seen, snp_seen;
  logic [2:0]   lat;
  logic [4:0]   rsp_seen;
  logic [31:0]  blk [1:6];
  logic [6:0]   cq [$];
  logic [29:0]  bq [$];
  logic [1:0]   sq [$];
  logic [31:0]  rq [$];
  int           num_errors = 0;
  int           comparisons = 0;
  int           cycles = 0;

  mdc_coherency #(.SETS(128)) u_dut (
    .clk_i, .rst_n_i, .cpu_req_valid_i, .cpu_req_i, .cpu_ready_o,
    .cpu_rsp_o, .bus_req_o, .bus_done_i, .bus_retry_n_i, .bus_shared_n_i,
    .snoop_i, .snoop_retry_n_o, .snoop_shared_n_o, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);

  mdc_bus_model u_bus (
    .clk_i, .rst_n_i, .bus_req_i(bus_req_o), .lat_i(lat),
    .shared_i(shared), .retry_i(retry), .done_o(bus_done_i),
    .retry_n_o(bus_retry_n_i), .shared_n_o(bus_shared_n_i));

  // Clock, 10 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  assign rsp_seen = {cpu_rsp_o.mem_write, cpu_rsp_o.refused, cpu_rsp_o.state};

  // Watcher: oldest note against each result that appears
  always @(posedge clk_i)
  begin
    logic [31:0] r;
    logic [29:0] b;
    logic [6:0]  c;
    logic [1:0]  s;
    if (re_seen)
    begin
      r = rq.pop_front();
      `CHK("reg_rdata", r, reg_rdata_o)
    end
    if (snp_seen)
    begin
      s = sq.pop_front();
      `CHK("snoop", s, {snoop_retry_n_o, snoop_shared_n_o})
    end
    if (bus_done_i && bus_req_o.valid)
    begin
      b = bq.pop_front();
      `CHK("bus_op", b, {bus_req_o.op, bus_req_o.addr[31:5]})
    end
    if (cpu_rsp_o.done)
    begin
      c = cq.pop_front();
      `CHK("rsp", c[4:0], rsp_seen)
      if (c[6]) `CHK("hit", c[5], cpu_rsp_o.cache_hit)
    end
    re_seen = reg_re_i;
    snp_seen = !snoop_i.xfer_begin_n;
  end

  // Verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Random byte inside a block
  function automatic logic [31:0] ad(input int i);
    return blk[i] | 32'($urandom_range(31));
  endfunction

  // Request {store, attributes, guarded and speculative}, held until taken
  task automatic cpu(input logic [31:0] a, input logic [4:0] f,
                     input logic [6:0] ex);
    cq.push_back(ex);
    @(posedge clk_i);
    lat <= 3'($urandom_range(5));
    cpu_req_valid_i <= 1'b1;
    cpu_req_i <= '{a, f[4], f[3:1], f[0], f[0]};
    do @(posedge clk_i); while (cpu_ready_o !== 1'b1);
    cpu_req_valid_i <= 1'b0;
    cpu_req_i <= ~cpu_req_i;
  endtask

  // One forwarded snoop, one cycle long
  task automatic snp(input mdc_bop_t op, input logic [31:0] a,
                     input logic qn, input logic [1:0] ex);
    sq.push_back(ex);
    @(posedge clk_i);
    snoop_i <= '{1'b0, qn, 1'b0, op, a};
    @(posedge clk_i);
    snoop_i <= ~snoop_i;
  endtask

  // Register write, or read with its expected data
  task automatic reg_op(input logic we, input logic [3:0] a,
                        input logic [31:0] d);
    if (!we)
      rq.push_back(d);
    @(posedge clk_i);
    reg_we_i <= we;
    reg_re_i <= !we;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
  endtask

  // Wait until every processor, bus and snoop note has been matched
  task automatic settle();
    while (cq.size() + bq.size() + sq.size() != 0 || !cpu_ready_o)
      @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask

  // Main sequence
  initial
  begin
    {rst_n_i, cpu_req_valid_i, reg_we_i, reg_re_i} = 4'h0;
    {shared, retry, re_seen, snp_seen, lat} = 7'h0;
    {reg_addr_i, reg_wdata_i} = 36'h0;
    cpu_req_i = '0;
    snoop_i = '{1'b1, 1'b1, 1'b0, BOP_NONE, 32'h0};
    void'($urandom(75));
    for (int i = 1; i <= 6; i++)
      blk[i] = {20'($urandom), 7'(i), 5'h0};
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reg_op(1'b0, REG_CTRL, 32'(CTRL_RESET));
    reg_op(1'b0, REG_STATUS, 32'h0);
    reg_op(1'b0, 4'hc, 32'h0);
    bq.push_back({BOP_READ, blk[1][31:5]});
    cpu(ad(1), 5'h02, {4'b0000, MESI_E});
    cpu(ad(1), 5'h02, {4'b1100, MESI_E});
    cpu(ad(1), 5'h12, {4'b1100, MESI_M});
    settle();
    shared <= 1'b1;
    bq.push_back({BOP_READ, blk[2][31:5]});
    cpu(ad(2), 5'h02, {4'b0000, MESI_S});
    settle();
    shared <= 1'b0;
    retry <= 1'b1;
    bq.push_back({BOP_KILL, blk[2][31:5]});
    bq.push_back({BOP_KILL, blk[2][31:5]});
    bq.push_back({BOP_RFO, blk[3][31:5]});
    cpu(ad(2), 5'h12, {4'b0000, MESI_M});
    cpu(ad(3), 5'h12, {4'b0000, MESI_M});
    settle();
    retry <= 1'b0;
    bq.push_back({BOP_READ_SINGLE, blk[1][31:5]});
    bq.push_back({BOP_WRITE, blk[1][31:5]});
    cpu(ad(1), 5'h06, {4'b1000, MESI_M});
    cpu(ad(1), 5'h18, {4'b1110, MESI_M});
    cpu(ad(5), 5'h03, {4'b1001, MESI_I});
    settle();
    bq.push_back({BOP_PUSH, blk[2][31:5]});
    snp(BOP_READ, ad(2), 1'b0, 2'b01);
    cpu(ad(2), 5'h02, {4'b1100, MESI_S});
    settle();
    reg_op(1'b0, REG_RETRIES, 32'h1);
    reg_op(1'b1, REG_RETRIES, 32'h0);
    reg_op(1'b0, REG_RETRIES, 32'h0);
    snp(BOP_RFO, ad(2), 1'b0, 2'b10);
    snp(BOP_READ, ad(1) ^ 32'h8000_0000, 1'b0, 2'b11);
    snp(BOP_READ, ad(3), 1'b1, 2'b11);
    bq.push_back({BOP_READ, blk[2][31:5]});
    bq.push_back({BOP_READ, blk[4][31:5]});
    cpu(ad(2), 5'h02, {4'b0000, MESI_E});
    cpu(ad(4), 5'h02, {4'b0000, MESI_E});
    settle();
    snp(BOP_READ, ad(4), 1'b0, 2'b10);
    bq.push_back({BOP_KILL, blk[4][31:5]});
    cpu(ad(4), 5'h12, {4'b0000, MESI_M});
    settle();
    `CHK("left", 0, cq.size() + bq.size() + sq.size() + rq.size())
    complete_run();
  end

endmodule // mdc_coherency_test

`default_nettype wire
